/* File: cbp_map.svh */
// Register offsets, field positions, reset values and timing counts
// for the balance permission block.
// Assumes inclusion by bare name from a package or a module.
`ifndef CBP_MAP_SVH
`define CBP_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define CBP_OFS_SETUP        8'h00
`define CBP_OFS_CHG_THR      8'h04
`define CBP_OFS_DSG_THR      8'h08
`define CBP_OFS_INTERVAL     8'h0c
`define CBP_OFS_HOST_CMD     8'h10
`define CBP_OFS_STATUS       8'h14

// ----------------------------------------------------------------
// Field positions of balance_setup
// ----------------------------------------------------------------
`define CBP_BIT_CHG_EN       0
`define CBP_BIT_RLX_EN       1
`define CBP_BIT_BAL_LP       2
`define CBP_BIT_LP_INHIBIT   3
`define CBP_BIT_HOST_BLOCK   4
`define CBP_SETUP_USED_MASK  8'h1f

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CBP_RST_SETUP        8'h00
`define CBP_RST_CHG_THR      16'h0032
`define CBP_RST_DSG_THR      16'h0064
`define CBP_RST_INTERVAL     8'h14

// ----------------------------------------------------------------
// Timing: interval unit is one second at 100 MHz
// ----------------------------------------------------------------
`define CBP_CLK_HZ           100000000
`define CBP_SEC_S            1
`define CBP_SEC_CYCLES       (`CBP_SEC_S * `CBP_CLK_HZ)

`endif

/* File: cbp_pkg.sv */
// Types shared by the balance permission block.
// Assumes cbp_map.svh is on the include path.
`default_nettype none
package cbp_pkg;
  // Balancing configuration fields
  typedef struct packed {
    logic [2:0] rsvd;
    logic       host_balance_block;
    logic       lowpower_inhibit_on_balance;
    logic       balance_in_lowpower;
    logic       relax_balance_enable;
    logic       charge_balance_enable;
  } cbp_setup_s;

  // Pack current condition
  typedef enum logic [1:0] {
    CBP_RELAX,
    CBP_CHARGE,
    CBP_DISCHARGE
  } cbp_cond_e;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cbp_bus_s;
endpackage : cbp_pkg
`default_nettype wire

/* File: cbp_host_timer.sv */
// Host balancing hold timer: counts whole seconds of the balance interval.
// Assumes a one-cycle second tick from the caller's divider.
`default_nettype none
module cbp_host_timer
  import cbp_pkg::*;
(
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  // Control
  input  wire logic       i_sec_tick,
  input  wire logic       i_start,
  input  wire logic       i_stop,
  input  wire logic [7:0] i_interval,
  // Status
  output logic            o_active
);
  logic [7:0] remain_reg;
  logic [7:0] remain_next;

  // A restart reloads the full interval, so a reissue extends hold
  assign remain_next = i_start ? i_interval :
                       i_stop ? 8'h00 :
                       (i_sec_tick && remain_reg != 8'h00) ? remain_reg - 8'h01 :
                       remain_reg;

  // Seconds remaining
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      remain_reg <= 8'h00;
    end else begin
      remain_reg <= remain_next;
    end
  end

  assign o_active = remain_reg != 8'h00;
endmodule : cbp_host_timer
`default_nettype wire

/* File: cbp_balance_permit.sv */
// Cell balancing permission: configuration, current classification,
// host command hold and sleep interaction.
// Assumes a single 100 MHz clock and a one-cycle-latency register port.
// Functional notes
// - Host balancing commands are ignored when bit 4 is set.
// - Bit 3 set blocks sleep entry while any balancing is active.
// - Bit 2 clear stops all balancing while in sleep.
// - Automatic balancing in relax needs bit 1.
// - Automatic balancing while charging needs bit 0.
// - Bits 1 and 0 gate automatic balancing only, not host balancing.
// - Charging when current exceeds the charge threshold, default 50.
// - Discharging when negative current magnitude exceeds threshold, default 100.
// - Host command holds balancing for the interval; reissue restarts it.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`include "cbp_map.svh"
`default_nettype none
module cbp_balance_permit
  import cbp_pkg::*;
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Measurement and system state
  input  wire logic [15:0] i_current,
  input  wire logic        i_auto_request,
  input  wire logic        i_lowpower_active,
  input  wire logic        i_lowpower_request,
  // Permission outputs
  output logic             o_balance_enable,
  output logic             o_host_active,
  output logic             o_lowpower_allow,
  output logic [1:0]       o_condition
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  cbp_setup_s  setup_reg;
  logic [15:0] chg_thr_reg;
  logic [15:0] dsg_thr_reg;
  logic [7:0]  interval_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [26:0] div_reg;
  logic        sec_tick_reg;
  cbp_cond_e   cond_reg;
  cbp_cond_e   cond_next;
  logic        enable_reg;
  logic        enable_next;
  logic        allow_reg;
  logic        allow_next;
  logic        host_reg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire sel_setup    = i_addr == `CBP_OFS_SETUP;
  wire sel_chg      = i_addr == `CBP_OFS_CHG_THR;
  wire sel_dsg      = i_addr == `CBP_OFS_DSG_THR;
  wire sel_interval = i_addr == `CBP_OFS_INTERVAL;
  wire sel_cmd      = i_addr == `CBP_OFS_HOST_CMD;
  wire sel_status   = i_addr == `CBP_OFS_STATUS;

  // Reserved bits never stored, so they always read zero
  wire [7:0] setup_wr_val = i_wdata[7:0] & `CBP_SETUP_USED_MASK;

  // Configuration writes
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      setup_reg    <= `CBP_RST_SETUP;
      chg_thr_reg  <= `CBP_RST_CHG_THR;
      dsg_thr_reg  <= `CBP_RST_DSG_THR;
      interval_reg <= `CBP_RST_INTERVAL;
    end else if (i_wr) begin
      if (sel_setup)    setup_reg    <= setup_wr_val;
      if (sel_chg)      chg_thr_reg  <= {1'b0, i_wdata[14:0]};
      if (sel_dsg)      dsg_thr_reg  <= {1'b0, i_wdata[14:0]};
      // An interval of zero is out of range; hold the minimum of one
      if (sel_interval) interval_reg <= (i_wdata[7:0] == 8'h00) ? 8'h01 : i_wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Host commands: bit 0 starts or restarts, bit 1 stops
  // ----------------------------------------------------------------
  wire cmd_write  = i_wr && sel_cmd && !setup_reg.host_balance_block;
  wire host_start = cmd_write && i_wdata[0];
  wire host_stop  = cmd_write && i_wdata[1];
  wire host_active;

  // ----------------------------------------------------------------
  // One-second tick
  // ----------------------------------------------------------------
  localparam logic [26:0] SEC_LAST = 27'(`CBP_SEC_CYCLES - 1);

  // Free-running divider; first tick may come early after a command
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg      <= 27'h0000000;
      sec_tick_reg <= 1'b0;
    end else begin
      div_reg      <= (div_reg == SEC_LAST) ? 27'h0000000 : div_reg + 27'h0000001;
      sec_tick_reg <= div_reg == SEC_LAST;
    end
  end

  cbp_host_timer u_host_timer (
    .i_sys_clk  (i_sys_clk),
    .i_resetn   (i_resetn),
    .i_sec_tick (sec_tick_reg),
    .i_start    (host_start),
    .i_stop     (host_stop),
    .i_interval (interval_reg),
    .o_active   (host_active)
  );

  // ----------------------------------------------------------------
  // Current classification (signed current, positive is charge)
  // ----------------------------------------------------------------
  wire signed [16:0] cur_s   = {i_current[15], i_current};
  wire signed [16:0] chg_s   = {1'b0, chg_thr_reg};
  wire signed [16:0] dsg_neg = -$signed({1'b0, dsg_thr_reg});
  wire is_charge    = cur_s > chg_s;
  wire is_discharge = cur_s < dsg_neg;

  assign cond_next = is_charge ? CBP_CHARGE :
                     is_discharge ? CBP_DISCHARGE : CBP_RELAX;

  // ----------------------------------------------------------------
  // Permission logic
  // ----------------------------------------------------------------
  // Enables apply to automatic balancing only; discharge never permits it
  wire auto_ok = i_auto_request &&
                 ((cond_next == CBP_CHARGE && setup_reg.charge_balance_enable) ||
                  (cond_next == CBP_RELAX && setup_reg.relax_balance_enable));
  wire want_balance = auto_ok || host_active;
  // Sleep without permission suppresses every kind of balancing
  wire lp_ok = !i_lowpower_active || setup_reg.balance_in_lowpower;

  assign enable_next = want_balance && lp_ok;
  // Hazard: relies on software pairing bit 3 with bit 2, else balancing stalls
  assign allow_next = i_lowpower_request &&
                      !(setup_reg.lowpower_inhibit_on_balance && want_balance);

  // Registered permission outputs
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cond_reg   <= CBP_RELAX;
      enable_reg <= 1'b0;
      allow_reg  <= 1'b0;
      host_reg   <= 1'b0;
    end else begin
      cond_reg   <= cond_next;
      enable_reg <= enable_next;
      allow_reg  <= allow_next;
      host_reg   <= host_active;
    end
  end

  // ----------------------------------------------------------------
  // Read path: data in the cycle after the strobe, zero otherwise
  // ----------------------------------------------------------------
  wire [31:0] status_word = {26'h0000000, cond_reg, allow_reg, enable_reg,
                             host_reg, i_lowpower_active};

  assign rdata_next = !i_rd        ? 32'h00000000 :
                      sel_setup    ? {24'h000000, setup_reg} :
                      sel_chg      ? {16'h0000, chg_thr_reg} :
                      sel_dsg      ? {16'h0000, dsg_thr_reg} :
                      sel_interval ? {24'h000000, interval_reg} :
                      sel_status   ? status_word :
                      32'h00000000;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata          = rdata_reg;
  assign o_balance_enable = enable_reg;
  assign o_host_active    = host_reg;
  assign o_lowpower_allow = allow_reg;
  assign o_condition      = cond_reg;
endmodule : cbp_balance_permit
`default_nettype wire

/* File: cbp_balance_permit_properties.sv */
// Port checker for the balance permission block.
// Assumes bind onto cbp_balance_permit, one clock domain.
`include "cbp_map.svh"
`default_nettype none
module cbp_balance_permit_properties (
  // Clock, reset, bus
  input wire logic        i_sys_clk,
  input wire logic        i_resetn,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  // Permission side
  input wire logic        i_auto_request,
  input wire logic        i_lowpower_active,
  input wire logic        i_lowpower_request,
  input wire logic        o_balance_enable,
  input wire logic        o_host_active,
  input wire logic        o_lowpower_allow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] sh_reg;
  wire logic  cmd_wr = i_wr && i_addr == `CBP_OFS_HOST_CMD && i_wdata[0];
  // Setup mirror; updates on the same edge as the real register
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) sh_reg <= 5'h00;
    else if (i_wr && i_addr == `CBP_OFS_SETUP) sh_reg <= i_wdata[4:0];
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  sequence blk_s; cmd_wr && sh_reg[4] && !o_host_active ##1 !o_host_active; endsequence
  sequence go_s; cmd_wr && !sh_reg[4] ##1 !i_lowpower_active; endsequence
  lp_block_a: assert property ($past(i_lowpower_active && !sh_reg[2]) |-> !o_balance_enable)
    else $error("balancing during sleep");
  auto_off_a: assert property (!$past(i_auto_request) && !o_host_active
    && $past(!o_host_active) |-> !o_balance_enable) else $error("balancing with no request");
  inhibit_a: assert property ($past(sh_reg[3]) && o_host_active && $past(o_host_active)
    |-> !o_lowpower_allow) else $error("sleep allowed while balancing");
  allow_off_a: assert property (!$past(i_lowpower_request) |-> !o_lowpower_allow)
    else $error("sleep allowed unasked");
  allow_on_a: assert property ($past(i_lowpower_request && !sh_reg[3]) |-> o_lowpower_allow)
    else $error("sleep refused");
  host_block_a: assert property (blk_s |=> !o_host_active) else $error("blocked command taken");
  host_start_a: assert property (go_s |=> o_host_active && o_balance_enable)
    else $error("host command not honoured");
  setup_read_a: assert property ($past(i_rd && i_addr == `CBP_OFS_SETUP)
    |-> o_rdata == {27'h0, $past(sh_reg)}) else $error("setup readback wrong");
endmodule : cbp_balance_permit_properties
bind cbp_balance_permit cbp_balance_permit_properties u_props (.i_sys_clk, .i_resetn, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_auto_request, .i_lowpower_active, .i_lowpower_request,
  .o_balance_enable, .o_host_active, .o_lowpower_allow);
`default_nettype wire

/* File: cbp_host_model.sv */
// Host controller model: issues register writes and reads.
// Assumes the slave never stalls and reads answer one cycle later.
`include "cbp_map.svh"
`default_nettype none
module cbp_host_model
  import cbp_pkg::*;
(
  // Clock in, bus out
  input  wire logic i_sys_clk,
  output var cbp_bus_s o_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_bus = '0;
  // One-cycle write strobe, dropped right after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    v = d;
    if (a == `CBP_OFS_SETUP && d[3]) v[2] = 1'b1;
    @(posedge i_sys_clk);
    o_bus <= '{a, v, 1'b1, 1'b0};
    @(posedge i_sys_clk);
    o_bus.wr <= 1'b0;
  endtask : wr
  // One-cycle read strobe
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    o_bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge i_sys_clk);
    o_bus.rd <= 1'b0;
  endtask : rd
endmodule : cbp_host_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the balance permission block.
// Assumes the host model drives the register port.
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module testbench
  import cbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, auto = 1'b0, lpa = 1'b0, lpr = 1'b0, rd_d = 1'b0;
  logic en, host, allow, ex;
  logic [7:0] rd_a = 8'h00;
  logic [1:0] cond, ec;
  logic [31:0] rdata, e_v;
  logic signed [15:0] cur = 16'sh0, c;
  logic signed [15:0] tbl[4] = '{16'sd50, 16'sd51, -16'sd100, -16'sd101};
  logic [31:0] exp_q[$];
  cbp_bus_s bus;
  int fails = 0, checks = 0, seed = 55;
  always #5 clk = ~clk;
  cbp_host_model u_host (.i_sys_clk(clk), .o_bus(bus));
  cbp_balance_permit u_dut (.i_sys_clk(clk), .i_resetn(resetn), .i_addr(bus.addr),
    .i_wdata(bus.wdata), .i_wr(bus.wr), .i_rd(bus.rd), .o_rdata(rdata), .i_current(cur),
    .i_auto_request(auto), .i_lowpower_active(lpa), .i_lowpower_request(lpr),
    .o_balance_enable(en), .o_host_active(host), .o_lowpower_allow(allow), .o_condition(cond));
  // Oldest note against each read answer
  always @(posedge clk) begin
    rd_d <= bus.rd;
    rd_a <= bus.addr;
    if (rd_d) begin
      e_v = exp_q.pop_front();
      `CHK("rdata", e_v, rdata)
      // Status reads also vouch for the output pins themselves
      if (rd_a == 8'h14) `CHK("ports", e_v[5:1], {cond, allow, en, host})
    end
  end
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask : rd
  // Status {cond, allow, enable, host, sleep} after inputs settle
  task automatic st(input logic [5:0] e);
    repeat (4) @(posedge clk);
    rd(8'h14, {26'h0, e});
  endtask : st
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // Watchdog far beyond the few hundred cycles needed
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h32);
    rd(8'h08, 32'h64);
    rd(8'h0c, 32'h14);
    rd(8'h20, 32'h0);
    u_host.wr(8'h00, 32'he3);
    rd(8'h00, 32'h03);
    $display("test reset done");
    auto <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      c = k < 4 ? tbl[k] : 16'($random(seed) % 300);
      ec = c > 50 ? 2'h1 : c < -100 ? 2'h2 : 2'h0;
      ex = (ec == 2'h1 && k[0]) || (ec == 2'h0 && k[1]);
      u_host.wr(8'h00, 32'(k % 4));
      cur <= c;
      st({ec, 1'b0, ex, 2'b00});
    end
    $display("test auto done");
    cur <= 16'sh0;
    lpa <= 1'b1;
    u_host.wr(8'h00, 32'h02);
    st(6'h01);
    u_host.wr(8'h00, 32'h06);
    st(6'h05);
    $display("test sleep done");
    {lpa, auto, lpr} <= 3'b001;
    u_host.wr(8'h00, 32'h08);
    u_host.wr(8'h10, 32'h1);
    st(6'h06);
    u_host.wr(8'h00, 32'h04);
    st(6'h0e);
    u_host.wr(8'h10, 32'h2);
    st(6'h08);
    $display("test inhibit done");
    lpr <= 1'b0;
    u_host.wr(8'h00, 32'h10);
    u_host.wr(8'h10, 32'h1);
    st(6'h00);
    u_host.wr(8'h00, 32'h00);
    u_host.wr(8'h10, 32'h1);
    st(6'h06);
    u_host.wr(8'h10, 32'h3);
    st(6'h06);
    u_host.wr(8'h0c, 32'h0);
    rd(8'h0c, 32'h1);
    $display("test host done");
    u_host.wr(8'h04, 32'h8010);
    rd(8'h04, 32'h10);
    cur <= 16'sd17;
    st(6'h16);
    u_host.wr(8'h08, 32'h5);
    cur <= -16'sd6;
    st(6'h26);
    $display("test threshold done");
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
